// ===== rst_ctl_pkg.sv
// constants, register map and types of the reset source controller
// assumes a 20 MHz system clock and a 16-bit register port
package rst_ctl_pkg;

  // register port
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADR_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] ADR_WDT = 3'h1;
  localparam logic [ADDR_W-1:0] ADR_WDT_PER = 3'h2;
  localparam logic [ADDR_W-1:0] ADR_SUPV = 3'h3;
  localparam logic [ADDR_W-1:0] ADR_LEVEL = 3'h4;
  localparam logic [ADDR_W-1:0] ADR_STATUS = 3'h5;
  localparam logic [ADDR_W-1:0] ADR_IRQ = 3'h6;

  // control register fields
  localparam int CTRL_SWRST = 0;
  localparam int CTRL_SWDIS = 1;
  localparam int CTRL_ANAEN = 2;
  localparam int CTRL_PINMODE = 3;
  localparam logic CTRL_SWDIS_RST = 1'h0;
  localparam logic CTRL_ANAEN_RST = 1'h1;
  localparam logic CTRL_PINMODE_RST = 1'h0;

  // watchdog register fields
  localparam int WDT_EN_BIT = 0;
  localparam int WDT_KICK_BIT = 1;
  localparam int WDT_PER_W = 8;
  localparam logic [WDT_PER_W-1:0] WDT_PER_RST = 8'hFF;
  localparam int WDT_PRESCALE = 1024;

  // supervisor enable register fields
  localparam int SUPV_W = 5;
  localparam int SUPV_ALV_EN = 0;
  localparam int SUPV_DLV_EN = 1;
  localparam int SUPV_AHV_EN = 2;
  localparam int SUPV_ALV_RST = 3;
  localparam int SUPV_DLV_RST = 4;
  localparam logic [SUPV_W-1:0] SUPV_RST = 5'h00;

  // threshold codes: trip = LV_BASE_MV + code * LV_STEP_MV
  localparam int LVL_W = 4;
  localparam int LVL_ALV_LSB = 0;
  localparam int LVL_DLV_LSB = 4;
  localparam logic [2*LVL_W-1:0] LEVEL_RST = 8'h00;
  localparam int LV_BASE_MV = 1700;
  localparam int LV_STEP_MV = 250;
  localparam int AHV_TRIP_MV = 5750;

  // cause flags, also the source vector order (low index wins)
  localparam int NSRC = 9;
  localparam int SRC_INITIAL_POWER_ON_RESET = 0;
  localparam int SRC_PRECISE_LOW_VOLTAGE_RESET = 1;
  localparam int SRC_EXT = 2;
  localparam int SRC_ROUTED = 3;
  localparam int SRC_WDT = 4;
  localparam int SRC_SW = 5;
  localparam int SRC_ALV = 6;
  localparam int SRC_DLV = 7;
  localparam int SRC_AHV = 8;
  localparam logic [NSRC-1:0] STATUS_RST = 9'h001;

  // supervisor interrupt pending bits
  localparam int IRQ_W = 3;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int INITIAL_POWER_ON_RESET_MIN_NS = 100;
  localparam int INITIAL_POWER_ON_RESET_CYC_RAW = (INITIAL_POWER_ON_RESET_MIN_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
  localparam int INITIAL_POWER_ON_RESET_CYC = (INITIAL_POWER_ON_RESET_CYC_RAW < 1) ? 1 : INITIAL_POWER_ON_RESET_CYC_RAW;
  localparam int CNT_W = 4;

  typedef enum logic [1:0] {
    PH_INITIAL_POWER_ON_RESET,
    PH_PRECISE_LOW_VOLTAGE_RESET,
    PH_RUN
  } phase_t;

endpackage : rst_ctl_pkg

// ===== wdt_timer.sv
// watchdog interval timer: prescaled count, reload on service
// assumes enable and service come from flops in the same clock domain
`timescale 1ns/10ps
module wdt_timer
  import rst_ctl_pkg::*;
#(
  parameter int PRESCALE = WDT_PRESCALE,
  parameter int PER_W = WDT_PER_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic enable_i,
  input wire logic service_i,
  input wire logic [PER_W-1:0] period_i,
  // timeout
  output logic bark_o
);

  localparam int PRE_W = $clog2(PRESCALE);

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [PER_W-1:0] cnt;
    logic bark;
  } wdt_state_t;

  wdt_state_t s_r;
  wdt_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.bark = 1'b0;
    if (service_i || !enable_i) begin
      s_nxt.pre = '0;
      s_nxt.cnt = '0;
    end else if (s_r.pre == PRE_W'(PRESCALE - 1)) begin
      s_nxt.pre = '0;
      if (s_r.cnt == period_i) begin
        // interval missed: one pulse, then start over
        s_nxt.bark = 1'b1; // [RULE3]
        s_nxt.cnt = '0;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end else begin
      s_nxt.pre = s_r.pre + 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bark_o = s_r.bark;

endmodule : wdt_timer

// ===== reset_source_controller.sv
// reset source controller: gathers supply, pin, routed, software and
// watchdog resets into one device reset and records the latest cause
// assumes comparator and pin inputs are synchronous, RESET_I is power-on
//
// What this block does
// RULE1 - any supply monitor except the high voltage one can reset the device
// RULE2 - low external reset pin holds the device in reset like power-on
// RULE3 - firmware services watchdog; missed interval produces watchdog reset
// RULE4 - writing the software reset bit resets the device like power-on
// RULE5 - a separate disable bit makes software reset writes harmless
// RULE6 - status register holds the latest reset or monitor cause, readable
// RULE7 - power-on reset clears status; other resets keep it
// RULE8 - power-on reset pulse lasts at least 100 ns, longer on slow ramp
// RULE9 - power-on monitor hands off to precise reset; oscillator starts after
// RULE10 - precise low voltage trip resets exactly like power-on; here it is a device reset that keeps watchdog enable and pin mode
// RULE11 - digital precise reset cannot be disabled; analog follows regulator
// RULE12 - precise reset off in sleep and hibernate, on during buzz in sleep (not in hibernate)
// RULE13 - low thresholds in 250 mV steps; high threshold fixed 5.75 V
// RULE14 - each low voltage supervisor may reset instead of interrupt
// RULE15 - supervisors can interrupt early, before reset thresholds
// RULE16 - supervisors stay disabled until power-on reset completes
// RULE17 - interrupt during buzz first wakes device, then gets serviced
// RULE18 - external reset pin works in sleep and hibernate
// RULE19 - routed logic reset acts only with the pin in reset mode
// RULE20 - power-on disables watchdog; enable bit sticks, ignores zero
// RULE21 - device reset returns control registers to reset state, except watchdog enable and pin mode
// RULE22 - one status flag per source; the latest event's flag is set
// RULE23 - pin and routed reset pass a two-flop synchroniser
`timescale 1ns/10ps
module reset_source_controller
  import rst_ctl_pkg::*;
#(
  parameter int WDT_PRE = WDT_PRESCALE
) (
  // clock and power-on reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  // register port
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [DATA_W-1:0] RDATA_O,
  // supply comparators, high while out of range, except DIG_STABLE_I, high while stable
  input wire logic POR_TRIP_I,
  input wire logic DIG_STABLE_I,
  input wire logic PRECISE_LOW_VOLTAGE_RESET_DIG_TRIP_I,
  input wire logic PRECISE_LOW_VOLTAGE_RESET_ANA_TRIP_I,
  input wire logic ALV_TRIP_I,
  input wire logic DLV_TRIP_I,
  input wire logic AHV_TRIP_I,
  // external and routed resets
  input wire logic EXT_RESET_N_I,
  input wire logic ROUTED_RESET_I,
  // power mode
  input wire logic SLEEP_I,
  input wire logic HIBERNATE_I,
  input wire logic BUZZ_I,
  input wire logic WAKE_DONE_I,
  // reset and monitor control
  output logic DEVICE_RESET_O,
  output logic IMO_EN_O,
  output logic INITIAL_POWER_ON_RESET_MON_EN_O,
  output logic PRECISE_LOW_VOLTAGE_RESET_DIG_EN_O,
  output logic PRECISE_LOW_VOLTAGE_RESET_ANA_EN_O,
  output logic ANA_REG_EN_O,
  output logic [IRQ_W-1:0] SUPV_EN_O,
  output logic [LVL_W-1:0] ALV_LEVEL_O,
  output logic [LVL_W-1:0] DLV_LEVEL_O,
  // interrupt and wakeup
  output logic SUPV_IRQ_O,
  output logic WAKE_REQ_O
);

  typedef struct packed {
    phase_t phase;
    logic [CNT_W-1:0] initial_power_on_reset_cnt;
    logic [CNT_W-1:0] hold_cnt;
    logic dev_rst;
    logic ext_s1;
    logic ext_s2;
    logic rte_s1;
    logic rte_s2;
    logic sw_dis;
    logic ana_en;
    logic pin_mode;
    logic swreq;
    logic wdt_en;
    logic kick;
    logic [WDT_PER_W-1:0] wdt_per;
    logic [SUPV_W-1:0] supv;
    logic [2*LVL_W-1:0] level;
    logic [NSRC-1:0] src_prev;
    logic [NSRC-1:0] status;
    logic [IRQ_W-1:0] irq_pend;
    logic wake_pend;
    logic [DATA_W-1:0] rdata;
  } ctl_state_t;

  ctl_state_t s_r;
  ctl_state_t s_nxt;

  // lowest index of a set bit, as one-hot
  function automatic logic [NSRC-1:0] first_one(input logic [NSRC-1:0] v);
    logic [NSRC-1:0] r;
    r = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction : first_one

  function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
    return WR_I && !s_r.dev_rst && (ADDR_I == a);
  endfunction : wr_hit

  logic low_power;
  logic monitor_on;
  logic precise_low_voltage_reset_trip;
  logic supv_on;
  logic [IRQ_W-1:0] supv_hit;
  logic alv_rst;
  logic dlv_rst;
  logic wdt_bark;
  logic [NSRC-1:0] src;
  logic [NSRC-1:0] src_rise;
  logic rst_req;

  wdt_timer #(
    .PRESCALE(WDT_PRE),
    .PER_W(WDT_PER_W)
  ) u_wdt (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .enable_i(s_r.wdt_en),
    .service_i(s_r.kick || s_r.dev_rst),
    .period_i(s_r.wdt_per),
    .bark_o(wdt_bark)
  );

  always_comb begin
    low_power = SLEEP_I || HIBERNATE_I;
    // monitors run awake, and in sleep only while the regulators buzz
    monitor_on = !low_power || (SLEEP_I && !HIBERNATE_I && BUZZ_I); // [RULE12]
    // digital part has no software enable at all
    precise_low_voltage_reset_trip = (s_r.phase != PH_INITIAL_POWER_ON_RESET) && monitor_on &&
                (PRECISE_LOW_VOLTAGE_RESET_DIG_TRIP_I ||
                 (s_r.ana_en && PRECISE_LOW_VOLTAGE_RESET_ANA_TRIP_I)); // [RULE11] [RULE1]
    supv_on = (s_r.phase == PH_RUN) && monitor_on; // [RULE16]
    supv_hit[0] = supv_on && s_r.supv[SUPV_ALV_EN] && ALV_TRIP_I;
    supv_hit[1] = supv_on && s_r.supv[SUPV_DLV_EN] && DLV_TRIP_I;
    supv_hit[2] = supv_on && s_r.supv[SUPV_AHV_EN] && AHV_TRIP_I;
    alv_rst = supv_hit[0] && s_r.supv[SUPV_ALV_RST]; // [RULE14]
    dlv_rst = supv_hit[1] && s_r.supv[SUPV_DLV_RST]; // [RULE14]
    src = '0;
    src[SRC_INITIAL_POWER_ON_RESET] = (s_r.phase != PH_RUN);
    // the power-up hand-off is not a trip of its own
    src[SRC_PRECISE_LOW_VOLTAGE_RESET] = precise_low_voltage_reset_trip && (s_r.phase == PH_RUN); // [RULE10]
    src[SRC_EXT] = s_r.ext_s2; // [RULE2] [RULE18]
    src[SRC_ROUTED] = s_r.rte_s2 && s_r.pin_mode; // [RULE19]
    src[SRC_WDT] = wdt_bark; // [RULE3]
    src[SRC_SW] = s_r.swreq; // [RULE4]
    src[SRC_ALV] = supv_hit[0];
    src[SRC_DLV] = supv_hit[1];
    src[SRC_AHV] = supv_hit[2];
    src_rise = src & ~s_r.src_prev;
    rst_req = (|src[SRC_SW:SRC_INITIAL_POWER_ON_RESET]) || alv_rst || dlv_rst;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = '0;
    s_nxt.swreq = 1'b0;
    s_nxt.kick = 1'b0;
    s_nxt.src_prev = src;

    // first flops only feed the second ones
    s_nxt.ext_s1 = !EXT_RESET_N_I; // [RULE23]
    s_nxt.ext_s2 = s_r.ext_s1; // [RULE23]
    s_nxt.rte_s1 = ROUTED_RESET_I; // [RULE23]
    s_nxt.rte_s2 = s_r.rte_s1; // [RULE23]

    // power-up sequence
    unique case (s_r.phase)
      PH_INITIAL_POWER_ON_RESET: begin
        if (s_r.initial_power_on_reset_cnt != CNT_W'(INITIAL_POWER_ON_RESET_CYC)) begin
          s_nxt.initial_power_on_reset_cnt = s_r.initial_power_on_reset_cnt + 1'b1;
        end else if (!POR_TRIP_I && DIG_STABLE_I) begin
          s_nxt.phase = PH_PRECISE_LOW_VOLTAGE_RESET; // [RULE8] [RULE9]
        end
      end
      PH_PRECISE_LOW_VOLTAGE_RESET: begin
        if (!PRECISE_LOW_VOLTAGE_RESET_DIG_TRIP_I && !(s_r.ana_en && PRECISE_LOW_VOLTAGE_RESET_ANA_TRIP_I)) begin
          s_nxt.phase = PH_RUN; // [RULE9]
        end
      end
      PH_RUN: begin
        s_nxt.phase = PH_RUN;
      end
    endcase

    // stretch every request so the device pulse meets the minimum width
    if (rst_req) begin
      s_nxt.hold_cnt = CNT_W'(INITIAL_POWER_ON_RESET_CYC);
    end else if (s_r.hold_cnt != '0) begin
      s_nxt.hold_cnt = s_r.hold_cnt - 1'b1;
    end
    s_nxt.dev_rst = rst_req || (s_r.hold_cnt != '0); // [RULE1]

    // latest cause only; status survives device resets
    if (|src_rise) begin
      s_nxt.status = first_one(src_rise); // [RULE6] [RULE22] [RULE7]
    end

    // register writes
    if (wr_hit(ADR_CTRL)) begin
      s_nxt.swreq = WDATA_I[CTRL_SWRST] && !s_r.sw_dis; // [RULE4] [RULE5]
      s_nxt.sw_dis = WDATA_I[CTRL_SWDIS]; // [RULE5]
      s_nxt.ana_en = WDATA_I[CTRL_ANAEN]; // [RULE11]
      s_nxt.pin_mode = WDATA_I[CTRL_PINMODE]; // [RULE19]
    end
    if (wr_hit(ADR_WDT)) begin
      // zero writes cannot turn the watchdog off
      s_nxt.wdt_en = s_r.wdt_en || WDATA_I[WDT_EN_BIT]; // [RULE20]
      s_nxt.kick = WDATA_I[WDT_KICK_BIT]; // [RULE3]
    end
    if (wr_hit(ADR_WDT_PER)) begin
      s_nxt.wdt_per = WDATA_I[WDT_PER_W-1:0];
    end
    if (wr_hit(ADR_SUPV)) begin
      s_nxt.supv = WDATA_I[SUPV_W-1:0]; // [RULE14] [RULE15]
    end
    if (wr_hit(ADR_LEVEL)) begin
      s_nxt.level = WDATA_I[2*LVL_W-1:0]; // [RULE13]
    end

    // pending interrupts: write one to clear, a new hit wins
    if (wr_hit(ADR_IRQ)) begin
      s_nxt.irq_pend = s_r.irq_pend & ~WDATA_I[IRQ_W-1:0];
    end
    s_nxt.irq_pend = s_nxt.irq_pend |
                     (supv_hit & ~{1'b0, dlv_rst, alv_rst}); // [RULE15]

    // a hit while asleep waits for the wakeup sequence to finish
    if (SLEEP_I && (|supv_hit)) begin
      s_nxt.wake_pend = 1'b1; // [RULE17]
    end else if (WAKE_DONE_I) begin
      s_nxt.wake_pend = 1'b0; // [RULE17]
    end

    // register reads, data valid only in the following cycle
    if (RD_I) begin
      unique case (ADDR_I)
        ADR_CTRL: begin
          s_nxt.rdata[CTRL_SWDIS] = s_r.sw_dis;
          s_nxt.rdata[CTRL_ANAEN] = s_r.ana_en;
          s_nxt.rdata[CTRL_PINMODE] = s_r.pin_mode;
        end
        ADR_WDT: s_nxt.rdata[WDT_EN_BIT] = s_r.wdt_en;
        ADR_WDT_PER: s_nxt.rdata = DATA_W'(s_r.wdt_per);
        ADR_SUPV: s_nxt.rdata = DATA_W'(s_r.supv);
        ADR_LEVEL: s_nxt.rdata = DATA_W'(s_r.level);
        ADR_STATUS: s_nxt.rdata = DATA_W'(s_r.status); // [RULE6]
        ADR_IRQ: s_nxt.rdata = DATA_W'(s_r.irq_pend);
        default: s_nxt.rdata = '0;
      endcase
    end

    // device reset clears control state but not cause, watchdog enable
    // or pin mode, which belong to power-on only
    if (s_r.dev_rst) begin
      s_nxt.sw_dis = CTRL_SWDIS_RST; // [RULE21]
      s_nxt.ana_en = CTRL_ANAEN_RST; // [RULE21]
      s_nxt.wdt_per = WDT_PER_RST; // [RULE21]
      s_nxt.supv = SUPV_RST; // [RULE21]
      s_nxt.level = LEVEL_RST; // [RULE21]
      s_nxt.irq_pend = '0; // [RULE21]
      s_nxt.wake_pend = 1'b0; // [RULE21]
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      s_r <= '0;
      s_r.phase <= PH_INITIAL_POWER_ON_RESET;
      s_r.dev_rst <= 1'b1;
      s_r.ana_en <= CTRL_ANAEN_RST;
      s_r.pin_mode <= CTRL_PINMODE_RST;
      s_r.wdt_per <= WDT_PER_RST;
      s_r.supv <= SUPV_RST;
      s_r.level <= LEVEL_RST;
      s_r.status <= STATUS_RST; // [RULE7]
      s_r.src_prev <= STATUS_RST;
      s_r.wdt_en <= 1'b0; // [RULE20]
    end else begin
      s_r <= s_nxt;
    end
  end

  assign RDATA_O = s_r.rdata;
  assign DEVICE_RESET_O = s_r.dev_rst;
  assign IMO_EN_O = (s_r.phase == PH_RUN); // [RULE9]
  assign INITIAL_POWER_ON_RESET_MON_EN_O = (s_r.phase == PH_INITIAL_POWER_ON_RESET); // [RULE9]
  assign PRECISE_LOW_VOLTAGE_RESET_DIG_EN_O = (s_r.phase != PH_INITIAL_POWER_ON_RESET) && monitor_on; // [RULE12]
  assign PRECISE_LOW_VOLTAGE_RESET_ANA_EN_O = PRECISE_LOW_VOLTAGE_RESET_DIG_EN_O && s_r.ana_en; // [RULE11]
  assign ANA_REG_EN_O = s_r.ana_en;
  assign SUPV_EN_O = supv_on ? s_r.supv[SUPV_AHV_EN:SUPV_ALV_EN] : '0;
  assign ALV_LEVEL_O = s_r.level[LVL_ALV_LSB +: LVL_W]; // [RULE13]
  assign DLV_LEVEL_O = s_r.level[LVL_DLV_LSB +: LVL_W]; // [RULE13]
  assign SUPV_IRQ_O = (|s_r.irq_pend) && !s_r.wake_pend &&
                      !low_power; // [RULE17]
  assign WAKE_REQ_O = s_r.wake_pend;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);

  sequence s_ext_held;
    !EXT_RESET_N_I [*3];
  endsequence

  // spelled out so every term is a sampled value
  sequence s_sw_write;
    WR_I && !DEVICE_RESET_O && (ADDR_I == ADR_CTRL) &&
      WDATA_I[CTRL_SWRST];
  endsequence

  property p_ext_rst;
    s_ext_held |=> DEVICE_RESET_O;
  endproperty
  a_ext_rst: assert property (p_ext_rst) // [RULE2]
    else $error("pin reset held but device not in reset");

  property p_sw_rst;
    (s_sw_write ##0 !s_r.sw_dis) |=> ##1 DEVICE_RESET_O [*2];
  endproperty
  a_sw_rst: assert property (p_sw_rst) // [RULE4]
    else $error("software reset write gave no reset pulse");

  property p_sw_dis;
    (s_sw_write ##0 s_r.sw_dis) |=> !s_r.swreq;
  endproperty
  a_sw_dis: assert property (p_sw_dis) // [RULE5]
    else $error("disabled software reset still requested");

  property p_precise_low_voltage_reset_rst;
    precise_low_voltage_reset_trip |=> DEVICE_RESET_O ##1 DEVICE_RESET_O;
  endproperty
  a_precise_low_voltage_reset_rst: assert property (p_precise_low_voltage_reset_rst) // [RULE10]
    else $error("precise trip did not hold reset");

  property p_wdt_sticky;
    s_r.wdt_en |=> s_r.wdt_en;
  endproperty
  a_wdt_sticky: assert property (p_wdt_sticky) // [RULE20]
    else $error("watchdog enable dropped");

  property p_initial_power_on_reset_min;
    $fell(INITIAL_POWER_ON_RESET_MON_EN_O) |-> $past(INITIAL_POWER_ON_RESET_MON_EN_O, 2) && DEVICE_RESET_O;
  endproperty
  a_initial_power_on_reset_min: assert property (p_initial_power_on_reset_min) // [RULE8]
    else $error("power-on phase shorter than minimum");

  property p_imo_late;
    $rose(IMO_EN_O) |-> $past(!INITIAL_POWER_ON_RESET_MON_EN_O && !PRECISE_LOW_VOLTAGE_RESET_DIG_TRIP_I);
  endproperty
  a_imo_late: assert property (p_imo_late) // [RULE9]
    else $error("oscillator started before precise reset released");

  property p_supv_off;
    !IMO_EN_O |-> (SUPV_EN_O == '0) && !SUPV_IRQ_O;
  endproperty
  a_supv_off: assert property (p_supv_off) // [RULE16]
    else $error("supervisor active before power-on done");

  property p_wake_first;
    (SLEEP_I && (|supv_hit)) |=> WAKE_REQ_O && !SUPV_IRQ_O;
  endproperty
  a_wake_first: assert property (p_wake_first) // [RULE17]
    else $error("interrupt seen before wakeup");

  property p_status_keep;
    !(|src_rise) |=> $stable(s_r.status);
  endproperty
  a_status_keep: assert property (p_status_keep) // [RULE7]
    else $error("status changed with no new cause");

endmodule : reset_source_controller

// ===== supply_model.sv
// supply comparators and external reset pin as the block sees them
// assumes rst_i is the power-on reset; the bench commands every fault
`timescale 1ns/10ps
module supply_model (
  // clock and power-on
  input wire logic clk_i,
  input wire logic rst_i,
  // commanded faults
  input wire logic sag_dig_i,
  input wire logic sag_ana_i,
  input wire logic pin_low_i,
  input wire logic [2:0] hit_i,
  // comparators and pin
  output logic por_trip_o,
  output logic dig_stable_o,
  output logic precise_low_voltage_reset_dig_trip_o,
  output logic precise_low_voltage_reset_ana_trip_o,
  output logic [2:0] lv_trip_o,
  output logic ext_reset_n_o
);
  logic [3:0] ramp_r;

  // slow ramp, so the power-on pulse is stretched well past its minimum
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ramp_r <= 4'h0;
    end else if (ramp_r != 4'hF) begin
      ramp_r <= ramp_r + 4'h1;
    end
  end

  assign por_trip_o = (ramp_r < 4'h8);
  assign dig_stable_o = (ramp_r >= 4'h6);
  assign precise_low_voltage_reset_dig_trip_o = (ramp_r < 4'hC) | sag_dig_i;
  assign precise_low_voltage_reset_ana_trip_o = sag_ana_i;
  assign lv_trip_o = hit_i;
  // pin has a pull-up: released reads high
  assign ext_reset_n_o = ~pin_low_i;
endmodule : supply_model

// ===== reset_source_controller_bench.sv
// self-checking bench of the reset source controller
// assumes supply_model drives the comparators and the reset pin
`timescale 1ns/10ps
module reset_source_controller_bench;
  import rst_ctl_pkg::*;
  logic CLK_SYS_I, RESET_I, WR_I, RD_I, ROUTED_RESET_I;
  logic SLEEP_I, HIBERNATE_I, BUZZ_I, WAKE_DONE_I;
  logic [ADDR_W-1:0] ADDR_I;
  logic [DATA_W-1:0] WDATA_I, RDATA_O;
  logic POR_TRIP_I, DIG_STABLE_I, PRECISE_LOW_VOLTAGE_RESET_DIG_TRIP_I, PRECISE_LOW_VOLTAGE_RESET_ANA_TRIP_I;
  logic EXT_RESET_N_I, DEVICE_RESET_O, IMO_EN_O, INITIAL_POWER_ON_RESET_MON_EN_O;
  logic PRECISE_LOW_VOLTAGE_RESET_DIG_EN_O, PRECISE_LOW_VOLTAGE_RESET_ANA_EN_O, ANA_REG_EN_O, SUPV_IRQ_O, WAKE_REQ_O;
  logic [IRQ_W-1:0] SUPV_EN_O, hit, lv;
  logic [LVL_W-1:0] ALV_LEVEL_O, DLV_LEVEL_O;
  logic sag_dig, sag_ana, pin_low;
  int n_mismatch, comparisons, k;

  reset_source_controller #(.WDT_PRE(4)) reset_source_controller_i (
    .CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .POR_TRIP_I(POR_TRIP_I), .DIG_STABLE_I(DIG_STABLE_I),
    .PRECISE_LOW_VOLTAGE_RESET_DIG_TRIP_I(PRECISE_LOW_VOLTAGE_RESET_DIG_TRIP_I), .PRECISE_LOW_VOLTAGE_RESET_ANA_TRIP_I(PRECISE_LOW_VOLTAGE_RESET_ANA_TRIP_I),
    .ALV_TRIP_I(lv[0]), .DLV_TRIP_I(lv[1]), .AHV_TRIP_I(lv[2]),
    .EXT_RESET_N_I(EXT_RESET_N_I), .ROUTED_RESET_I(ROUTED_RESET_I),
    .SLEEP_I(SLEEP_I), .HIBERNATE_I(HIBERNATE_I), .BUZZ_I(BUZZ_I),
    .WAKE_DONE_I(WAKE_DONE_I), .DEVICE_RESET_O(DEVICE_RESET_O),
    .IMO_EN_O(IMO_EN_O), .INITIAL_POWER_ON_RESET_MON_EN_O(INITIAL_POWER_ON_RESET_MON_EN_O),
    .PRECISE_LOW_VOLTAGE_RESET_DIG_EN_O(PRECISE_LOW_VOLTAGE_RESET_DIG_EN_O), .PRECISE_LOW_VOLTAGE_RESET_ANA_EN_O(PRECISE_LOW_VOLTAGE_RESET_ANA_EN_O),
    .ANA_REG_EN_O(ANA_REG_EN_O), .SUPV_EN_O(SUPV_EN_O),
    .ALV_LEVEL_O(ALV_LEVEL_O), .DLV_LEVEL_O(DLV_LEVEL_O),
    .SUPV_IRQ_O(SUPV_IRQ_O), .WAKE_REQ_O(WAKE_REQ_O));

  supply_model supply_model_i (
    .clk_i(CLK_SYS_I), .rst_i(RESET_I), .sag_dig_i(sag_dig),
    .sag_ana_i(sag_ana), .pin_low_i(pin_low), .hit_i(hit),
    .por_trip_o(POR_TRIP_I), .dig_stable_o(DIG_STABLE_I),
    .precise_low_voltage_reset_dig_trip_o(PRECISE_LOW_VOLTAGE_RESET_DIG_TRIP_I), .precise_low_voltage_reset_ana_trip_o(PRECISE_LOW_VOLTAGE_RESET_ANA_TRIP_I),
    .lv_trip_o(lv), .ext_reset_n_o(EXT_RESET_N_I));

  initial begin
    CLK_SYS_I = 1'b0;
    forever #25 CLK_SYS_I = ~CLK_SYS_I;
  end

  task wrap_up;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // returns just after an edge so outputs have settled
  task tick(input int n);
    repeat (n) @(posedge CLK_SYS_I);
    #1;
  endtask : tick

  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge CLK_SYS_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CLK_SYS_I);
    WR_I <= 1'b0;
  endtask : wr

  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge CLK_SYS_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLK_SYS_I);
    RD_I <= 1'b0;
    #1;
    chk(RDATA_O, exp);
  endtask : rd

  // bounded waits for a device reset to come and go, then the cause
  task await_rst(input logic [DATA_W-1:0] st);
    k = 0;
    while (DEVICE_RESET_O !== 1'b1 && k < 30) begin
      tick(1);
      k++;
    end
    chk(16'(DEVICE_RESET_O), 16'h0001);
    k = 0;
    while (DEVICE_RESET_O !== 1'b0 && k < 60) begin
      tick(1);
      k++;
    end
    chk(16'(DEVICE_RESET_O), 16'h0000);
    rd(ADR_STATUS, st);
  endtask : await_rst

  task por;
    @(posedge CLK_SYS_I);
    RESET_I <= 1'b1;
    repeat (16) @(posedge CLK_SYS_I);
    RESET_I <= 1'b0;
    tick(1);
    chk(16'(INITIAL_POWER_ON_RESET_MON_EN_O), 16'h0001);
    chk(16'(IMO_EN_O), 16'h0000);
    chk(16'(SUPV_EN_O), 16'h0000);
    k = 0;
    while (DEVICE_RESET_O !== 1'b0 && k < 60) begin
      tick(1);
      k++;
    end
    chk(16'(k >= 3), 16'h0001);
    chk(16'(DEVICE_RESET_O), 16'h0000);
    chk(16'(IMO_EN_O), 16'h0001);
    chk(16'(INITIAL_POWER_ON_RESET_MON_EN_O), 16'h0000);
  endtask : por

  task t_regs;
    rd(ADR_CTRL, 16'h0004);
    rd(ADR_WDT, 16'h0000);
    rd(ADR_WDT_PER, 16'h00FF);
    rd(ADR_SUPV, 16'h0000);
    rd(ADR_LEVEL, 16'h0000);
    rd(ADR_STATUS, 16'h0001);
    rd(ADR_IRQ, 16'h0000);
    rd(3'h7, 16'h0000);
  endtask : t_regs

  task t_soft;
    wr(ADR_CTRL, 16'h0006);
    wr(ADR_CTRL, 16'h0007);
    tick(8);
    chk(16'(DEVICE_RESET_O), 16'h0000);
    wr(ADR_CTRL, 16'h0004);
    wr(ADR_CTRL, 16'h0005);
    await_rst(16'h0020);
    rd(ADR_CTRL, 16'h0004);
  endtask : t_soft

  task t_routed;
    @(posedge CLK_SYS_I);
    ROUTED_RESET_I <= 1'b1;
    tick(8);
    chk(16'(DEVICE_RESET_O), 16'h0000);
    @(posedge CLK_SYS_I);
    ROUTED_RESET_I <= 1'b0;
    wr(ADR_CTRL, 16'h000C);
    @(posedge CLK_SYS_I);
    ROUTED_RESET_I <= 1'b1;
    tick(8);
    ROUTED_RESET_I <= 1'b0;
    await_rst(16'h0008);
    rd(ADR_CTRL, 16'h000C);
    wr(ADR_CTRL, 16'h0004);
  endtask : t_routed

  task t_precise;
    @(posedge CLK_SYS_I);
    sag_dig <= 1'b1;
    tick(3);
    sag_dig <= 1'b0;
    await_rst(16'h0002);
    wr(ADR_CTRL, 16'h0000);
    tick(1);
    chk(16'(ANA_REG_EN_O), 16'h0000);
    chk(16'(PRECISE_LOW_VOLTAGE_RESET_ANA_EN_O), 16'h0000);
    chk(16'(PRECISE_LOW_VOLTAGE_RESET_DIG_EN_O), 16'h0001);
    @(posedge CLK_SYS_I);
    sag_ana <= 1'b1;
    tick(6);
    sag_ana <= 1'b0;
    chk(16'(DEVICE_RESET_O), 16'h0000);
    wr(ADR_CTRL, 16'h0004);
  endtask : t_precise

  task t_supv;
    wr(ADR_LEVEL, 16'h0035);
    wr(ADR_SUPV, 16'h0005);
    tick(1);
    chk(16'(ALV_LEVEL_O), 16'h0005);
    chk(16'(DLV_LEVEL_O), 16'h0003);
    chk(16'(SUPV_EN_O), 16'h0005);
    for (int i = 0; i < 3; i++) begin
      @(posedge CLK_SYS_I);
      hit <= 3'(1 << i);
      tick(3);
      hit <= 3'h0;
      tick(2);
      chk(16'(SUPV_IRQ_O), (i == 1) ? 16'h0000 : 16'h0001);
      rd(ADR_IRQ, (i == 1) ? 16'h0000 : 16'(1 << i));
      rd(ADR_STATUS, (i == 2) ? 16'h0100 : 16'h0040);
      wr(ADR_IRQ, 16'h0007);
      rd(ADR_IRQ, 16'h0000);
    end
    wr(ADR_SUPV, 16'h0012);
    @(posedge CLK_SYS_I);
    hit <= 3'h2;
    tick(3);
    hit <= 3'h0;
    await_rst(16'h0080);
    rd(ADR_IRQ, 16'h0000);
    chk(16'(ALV_LEVEL_O), 16'h0000);
  endtask : t_supv

  task t_sleep;
    wr(ADR_SUPV, 16'h0001);
    @(posedge CLK_SYS_I);
    SLEEP_I <= 1'b1;
    tick(2);
    chk(16'(PRECISE_LOW_VOLTAGE_RESET_DIG_EN_O), 16'h0000);
    BUZZ_I <= 1'b1;
    tick(2);
    chk(16'(PRECISE_LOW_VOLTAGE_RESET_DIG_EN_O), 16'h0001);
    hit <= 3'h1;
    tick(3);
    hit <= 3'h0;
    tick(2);
    chk(16'(WAKE_REQ_O), 16'h0001);
    chk(16'(SUPV_IRQ_O), 16'h0000);
    BUZZ_I <= 1'b0;
    SLEEP_I <= 1'b0;
    tick(2);
    chk(16'(SUPV_IRQ_O), 16'h0000);
    WAKE_DONE_I <= 1'b1;
    tick(1);
    WAKE_DONE_I <= 1'b0;
    tick(2);
    chk(16'(SUPV_IRQ_O), 16'h0001);
    wr(ADR_IRQ, 16'h0001);
    @(posedge CLK_SYS_I);
    HIBERNATE_I <= 1'b1;
    pin_low <= 1'b1;
    tick(12);
    chk(16'(DEVICE_RESET_O), 16'h0001);
    pin_low <= 1'b0;
    HIBERNATE_I <= 1'b0;
    await_rst(16'h0004);
  endtask : t_sleep

  task t_wdt;
    wr(ADR_WDT_PER, 16'h0001);
    wr(ADR_WDT, 16'h0001);
    repeat (8) wr(ADR_WDT, 16'h0003);
    chk(16'(DEVICE_RESET_O), 16'h0000);
    wr(ADR_WDT, 16'h0000);
    rd(ADR_WDT, 16'h0001);
    await_rst(16'h0010);
    rd(ADR_WDT, 16'h0001);
    por;
    rd(ADR_WDT, 16'h0000);
    rd(ADR_STATUS, 16'h0001);
  endtask : t_wdt

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #1000000;
    n_mismatch++;
    wrap_up;
  end

  initial begin
    n_mismatch = 0;
    comparisons = 0;
    RESET_I = 1'b1;
    WR_I = 1'b0;
    RD_I = 1'b0;
    ADDR_I = '0;
    WDATA_I = '0;
    ROUTED_RESET_I = 1'b0;
    SLEEP_I = 1'b0;
    HIBERNATE_I = 1'b0;
    BUZZ_I = 1'b0;
    WAKE_DONE_I = 1'b0;
    sag_dig = 1'b0;
    sag_ana = 1'b0;
    pin_low = 1'b0;
    hit = '0;
    por;
    t_regs;
    t_soft;
    t_routed;
    t_precise;
    t_supv;
    t_sleep;
    t_wdt;
    wrap_up;
  end
endmodule : reset_source_controller_bench
